/* hdl/piv_controller.sv */
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
// ============================================================
// processor end: drives the i/o pulses, apb registers for software
module piv_controller
    import piv_pkg::*;
#(
    parameter logic [DEV_SEL_W-1:0] DEVICE_CODE = DEFAULT_DEV_CODE,
    parameter logic [NUM_GROUPS*ADDR_W-1:0] ADDR_TABLE = 30'h0,
    parameter logic PRI_EN_N = 1'b0,
    parameter int BTS_PERIOD = BTS_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [NUM_REQ-1:0] device_flag,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    piv_if.host bus
);

    typedef enum logic [3:0] {
        S_IDLE, S_SETUP, S_P2, S_GAP2, S_P1, S_GAP1, S_P4, S_GAP4, S_INIT
    } ctl_st_t;

    typedef struct packed {
        ctl_st_t st;
        op_t op;
        logic [NUM_REQ-1:0] flag_s1;    // synchroniser first stage
        logic [NUM_REQ-1:0] flag_s2;
        logic [BTS_CNT_W-1:0] bts_cnt;
        logic bts;
        logic [DEV_SEL_W-1:0] dev_sel;
        logic p1;
        logic p2;
        logic p4;
        logic init;
        logic [ADDR_W-1:0] vec;
        logic clr_seen;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_en;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic acc_phase;
    logic wr;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;

    // ============================================================
    // apb: one wait cycle, write acts at the edge pready is high
    assign acc_phase = psel & penable;
    assign wr = acc_phase & s_q.pready & pwrite;

    // ============================================================
    // next state
    always_comb begin
        s_d = s_q;
        ev = '0;
        clr = '0;
        if (ce) begin
            s_d.flag_s1 = device_flag;
            s_d.flag_s2 = s_q.flag_s1;
            // periodic sampling pulse for the request flops
            s_d.bts = 1'b0;
            if (s_q.bts_cnt >= BTS_CNT_W'(BTS_PERIOD - 1)) begin
                s_d.bts_cnt = '0;
                s_d.bts = 1'b1;
            end else begin
                s_d.bts_cnt = s_q.bts_cnt + 1'b1;
            end
            unique case (s_q.st)
                S_IDLE: begin
                    // commands arriving while busy are dropped
                    if (wr && paddr == OFS_CMD) begin
                        s_d.op = op_t'(pwdata[CMD_OP_LSB +: 2]);
                        if (s_d.op == OP_INIT) begin
                            s_d.st = S_INIT;
                        end else if (s_d.op != OP_NONE) begin
                            s_d.st = S_SETUP;
                        end
                    end
                end
                S_SETUP: s_d.st = (s_q.op == OP_END) ? S_P4 : S_P2;
                S_P2: s_d.st = S_GAP2;
                S_GAP2: begin
                    s_d.clr_seen = ~bus.clr_ac_level;
                    s_d.st = S_P1;
                end
                S_P1: s_d.st = S_GAP1;
                S_GAP1: begin
                    // sunk lines read as ones in the accumulator
                    s_d.vec = ~bus.accumulator_input_bus;
                    ev[IRQ_VEC] = 1'b1;
                    ev[IRQ_DONE] = 1'b1;
                    s_d.st = S_IDLE;
                end
                S_P4: s_d.st = S_GAP4;
                S_GAP4, S_INIT: begin
                    ev[IRQ_DONE] = 1'b1;
                    s_d.st = S_IDLE;
                end
                default: s_d.st = S_IDLE;
            endcase
            // selection code stays valid around each pulse
            s_d.dev_sel = (s_d.st inside {S_IDLE, S_INIT}) ?
                RST_DEV_SEL : DEVICE_CODE;
            s_d.p2 = (s_d.st == S_P2);
            s_d.p1 = (s_d.st == S_P1);
            s_d.p4 = (s_d.st == S_P4);
            s_d.init = (s_d.st == S_INIT);
            // registers
            if (wr && paddr == OFS_IRQ_CLEAR) begin
                clr = pwdata[IRQ_W-1:0];
            end
            if (wr && paddr == OFS_IRQ_ENABLE) begin
                s_d.irq_en = pwdata[IRQ_W-1:0];
            end
            // a new event beats a clear in the same cycle
            s_d.irq_st = (s_q.irq_st & ~clr) | ev;
            s_d.irq = |(s_d.irq_st & s_d.irq_en);
            s_d.pready = acc_phase & ~s_q.pready;
            s_d.pslverr = 1'b0;
            s_d.prdata = '0;
            if (acc_phase && !s_q.pready) begin
                unique case (paddr)
                    OFS_CMD, OFS_IRQ_CLEAR: ;
                    OFS_STATUS: begin
                        s_d.prdata[STATUS_BUSY] = (s_q.st != S_IDLE);
                        s_d.prdata[STATUS_CHAIN] = ~bus.pri_out_n;
                        s_d.prdata[STATUS_CLR_SEEN] = s_q.clr_seen;
                    end
                    OFS_VECTOR: s_d.prdata[ADDR_W-1:0] = s_q.vec;
                    OFS_IRQ_STATUS: s_d.prdata[IRQ_W-1:0] = s_q.irq_st;
                    OFS_IRQ_ENABLE: s_d.prdata[IRQ_W-1:0] = s_q.irq_en;
                    default: s_d.pslverr = 1'b1;
                endcase
            end
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
            s_q.st <= S_IDLE;
            s_q.op <= OP_NONE;
            s_q.irq_en <= RST_IRQ_EN;
            s_q.dev_sel <= RST_DEV_SEL;
        end else begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // outputs
    assign bus.dev_sel = s_q.dev_sel;
    assign bus.io_pulse_one = s_q.p1;
    assign bus.io_pulse_two = s_q.p2;
    assign bus.io_pulse_four = s_q.p4;
    assign bus.bit_time_state_pulse = s_q.bts;
    assign bus.initialize = s_q.init;
    assign bus.req_n = ~s_q.flag_s2;
    assign bus.addr_groups = ADDR_TABLE;
    assign bus.pri_en_n = PRI_EN_N;
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irq = s_q.irq;

endmodule : piv_controller

/* pkg/piv_pkg.sv */
// ============================================================
// shared constants and types for the priority vector link
package piv_pkg;

    // ============================================================
    // link geometry
    localparam int NUM_REQ = 4;        // request lines per module
    localparam int ADDR_W = 6;         // width of one address group
    localparam int NUM_GROUPS = 5;     // four priorities plus non-priority
    localparam int ACC_LSB = 6;        // lowest accumulator bit driven
    localparam int ACC_MSB = 11;       // highest accumulator bit driven
    localparam int DEV_SEL_W = 6;      // device selection code width

    // ============================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int BTS_PERIOD_NS = 1000;   // spacing of sampling pulses
    localparam int BTS_CYCLES_RAW = BTS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BTS_CYCLES = (BTS_CYCLES_RAW < 1) ? 1 : BTS_CYCLES_RAW;
    localparam int BTS_CNT_W = 16;

    // ============================================================
    // controller registers (byte offsets, one word each)
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_VECTOR = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

    // field positions
    localparam int CMD_OP_LSB = 0;
    localparam int STATUS_BUSY = 0;
    localparam int STATUS_CHAIN = 1;    // module passes priority on
    localparam int STATUS_CLR_SEEN = 2; // clear line seen low last service
    localparam int IRQ_VEC = 0;         // vector captured
    localparam int IRQ_DONE = 1;        // command finished
    localparam int IRQ_W = 2;

    // values after reset
    localparam logic [IRQ_W-1:0] RST_IRQ_EN = 2'h0;
    localparam logic [DEV_SEL_W-1:0] RST_DEV_SEL = 6'h00;
    localparam logic [DEV_SEL_W-1:0] DEFAULT_DEV_CODE = 6'h2a;

    // ============================================================
    // controller commands
    typedef enum logic [1:0] {
        OP_NONE,
        OP_SERVICE,
        OP_END,
        OP_INIT
    } op_t;

endpackage : piv_pkg

/* pkg/piv_if.sv */
`timescale 1ns/100ps
// ============================================================
// processor i/o bus between controller and priority module
interface piv_if;
    import piv_pkg::*;

    logic [DEV_SEL_W-1:0] dev_sel;
    logic io_pulse_one;
    logic io_pulse_two;
    logic io_pulse_four;
    logic bit_time_state_pulse;
    logic initialize;
    logic [NUM_REQ-1:0] req_n;
    logic [NUM_GROUPS*ADDR_W-1:0] addr_groups;
    logic pri_en_n;
    logic pri_out_n;
    logic [ADDR_W-1:0] acc_o;
    logic [ADDR_W-1:0] acc_oe;
    logic clr_ac_o;
    logic clr_ac_oe;
    logic [ADDR_W-1:0] accumulator_input_bus;
    logic clr_ac_level;

    // open-drain lines idle high, low where a driver sinks
    assign accumulator_input_bus = ~(acc_oe & ~acc_o);
    assign clr_ac_level = ~(clr_ac_oe & ~clr_ac_o);

    modport device (
        input dev_sel,
        input io_pulse_one,
        input io_pulse_two,
        input io_pulse_four,
        input bit_time_state_pulse,
        input initialize,
        input req_n,
        input addr_groups,
        input pri_en_n,
        output pri_out_n,
        output acc_o,
        output acc_oe,
        output clr_ac_o,
        output clr_ac_oe
    );

    modport host (
        output dev_sel,
        output io_pulse_one,
        output io_pulse_two,
        output io_pulse_four,
        output bit_time_state_pulse,
        output initialize,
        output req_n,
        output addr_groups,
        output pri_en_n,
        input pri_out_n,
        input accumulator_input_bus,
        input clr_ac_level
    );

endinterface : piv_if

/* hdl/priority_interrupt_vector.sv */
`timescale 1ns/100ps

// ============================================================
// priority interrupt vector module, device end of the bus
module priority_interrupt_vector
    import piv_pkg::*;
#(
    parameter logic [DEV_SEL_W-1:0] DEVICE_CODE = DEFAULT_DEV_CODE
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    piv_if.device bus,
    output logic [NUM_REQ-1:0] pending,
    output logic [NUM_REQ-1:0] winner
);

    // ============================================================
    // state
    typedef struct packed {
        logic [NUM_REQ-1:0] req;      // priority request flops
        logic [NUM_REQ-1:0] win;      // one-hot selection, for software view
        logic [ADDR_W-1:0] acc_oe;    // accumulator sink enables
        logic clr_oe;                 // clear-accumulator sink enable
        logic pri_out_n;              // enable for next lower module
    } dev_state_t;

    dev_state_t state_q;
    dev_state_t state_d;

    // ============================================================
    // service sequence as this module sees it
    // - selection code stands a cycle ahead of each pulse
    // - second pulse: clear line sunk the following cycle
    // - first pulse: vector sunk the following cycle, taken
    //   from the flops as they stand in the pulse cycle
    // - fourth pulse: every request flop drops
    // - sampling pulse: flops reload from the request lines,
    //   so a dropped flag clears its flop with no fourth pulse
    //
    // priority
    // - line 0 outranks line 3
    // - several flops may be set; only the highest is served
    // - enabled, no flop set: the non-priority group answers
    // - held off by the chain: nothing answers, vector zero
    // - a held-off module still samples and clears its flops
    //
    // reset and enable
    // - reset clears flops and sinks, chain output high
    // - a low clock enable freezes every flop, sinks too
    //
    // limits and hazards
    // - four lines per module; more need modules in a chain
    // - a sink lasts as long as its pulse, one cycle late;
    //   a long pulse gives a long sink
    // - a sample in the pulse cycle only reaches the next
    //   service, since the vector follows the flops
    // - the chain output lags the flops by a cycle, so a
    //   lower module may answer one cycle after this one wins
    // - the bus idles its selection lines at code zero, so
    //   a module wired to zero is selected whenever idle
    // - pending and winner are for software only; the bus
    //   sees the vector and the chain output

    // ============================================================
    // helpers

    // a loop, so the width follows the request count
    // lowest index is highest priority; result is one-hot or zero
    function automatic logic [NUM_REQ-1:0] pick_highest(
        input logic [NUM_REQ-1:0] req
    );
        logic [NUM_REQ-1:0] sel;
        logic taken;
        sel = '0;
        taken = 1'b0;
        for (int i = 0; i < NUM_REQ; i++) begin
            if (req[i] && !taken) begin
                sel[i] = 1'b1;
                taken = 1'b1;
            end
        end
        return sel;
    endfunction : pick_highest

    // group g sits at bits g*ADDR_W upwards
    // or of each group's hard-wired bits, gated by its selection
    function automatic logic [ADDR_W-1:0] gate_address(
        input logic [NUM_GROUPS-1:0] grp_sel,
        input logic [NUM_GROUPS*ADDR_W-1:0] groups
    );
        logic [ADDR_W-1:0] addr;
        addr = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            for (int b = 0; b < ADDR_W; b++) begin
                addr[b] = addr[b] | (grp_sel[g] & groups[g*ADDR_W+b]);
            end
        end
        return addr;
    endfunction : gate_address

    // ============================================================
    // combinational decode
    logic selected;
    logic enabled;
    logic none_set;
    logic [NUM_REQ-1:0] pick;
    logic [NUM_GROUPS-1:0] group_sel;
    logic [ADDR_W-1:0] vector;
    logic gated_pulse_one;
    logic gated_pulse_two;
    logic gated_pulse_four;

    // code match pre-enables the pulse gates
    assign selected = (bus.dev_sel == DEVICE_CODE);

    // grounded enable input means this module may answer
    assign enabled = ~bus.pri_en_n;

    // no flop set: nothing here wants service
    assign none_set = (state_q.req == '0);

    // one-hot pick, empty while the chain holds us off
    assign pick = enabled ? pick_highest(state_q.req) : '0;

    // fifth group is the non-priority address
    assign group_sel = {enabled & none_set, pick};
    assign vector = gate_address(group_sel, bus.addr_groups);

    // pulse gates; an unmatched code leaves the bus alone
    assign gated_pulse_one = selected & bus.io_pulse_one;
    assign gated_pulse_two = selected & bus.io_pulse_two;
    assign gated_pulse_four = selected & bus.io_pulse_four;

    // ============================================================
    // next state
    // the sinks last as long as their pulse, one edge after it;
    // the bus lines are driven only in the cycle after a selected pulse
    always_comb begin
        state_d = state_q;
        if (ce) begin
            // request flops: initialize, end of service, then sample
            if (bus.initialize) begin
                state_d.req = '0;
            end else if (gated_pulse_four) begin
                state_d.req = '0;
            end else if (bus.bit_time_state_pulse) begin
                // active-low lines, all four at once
                state_d.req = ~bus.req_n;
            end

            // software view of the selection, a cycle behind
            state_d.win = pick;

            // a set address bit sinks its accumulator line
            state_d.acc_oe = gated_pulse_one ? vector : '0;

            // clear line follows the second pulse
            state_d.clr_oe = gated_pulse_two;

            // pass the enable down only when nothing here wants service
            state_d.pri_out_n = ~(enabled & none_set);
        end
    end

    // ============================================================
    // state register
    // reset does not wait for the clock enable
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= '0;
            state_q.pri_out_n <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // ============================================================
    // outputs, all from flops except the tied-low sink values
    // open-drain lines only ever sink, so the value is low
    assign bus.acc_o = '0;
    assign bus.clr_ac_o = 1'b0;

    // sink enables and the chain output
    assign bus.acc_oe = state_q.acc_oe;
    assign bus.clr_ac_oe = state_q.clr_oe;
    assign bus.pri_out_n = state_q.pri_out_n;

    // software view
    assign pending = state_q.req;
    assign winner = state_q.win;

endmodule : priority_interrupt_vector

/* testbench/piv_properties.sv */
`timescale 1ns/100ps
// ============================================================
// link checks between the controller and the priority module
module piv_properties
    import piv_pkg::*;
#(
    parameter logic [DEV_SEL_W-1:0] DEVICE_CODE = DEFAULT_DEV_CODE
) (
    input logic mclk,
    input logic srst,
    input logic ce,
    input logic [DEV_SEL_W-1:0] dev_sel,
    input logic io_pulse_one,
    input logic io_pulse_two,
    input logic io_pulse_four,
    input logic bit_time_state_pulse,
    input logic initialize,
    input logic [NUM_REQ-1:0] req_n,
    input logic [NUM_GROUPS*ADDR_W-1:0] addr_groups,
    input logic pri_en_n,
    input logic pri_out_n,
    input logic [ADDR_W-1:0] acc_oe,
    input logic clr_ac_oe,
    input logic [NUM_REQ-1:0] pending,
    input logic [NUM_REQ-1:0] winner
);
    logic [ADDR_W-1:0] exp_vec;
    logic [NUM_REQ-1:0] exp_win;
    logic sel1;
    logic sel2;
    logic sel4;
    logic keep;
    logic busy_chain;

    // pulses only count with the wired code
    assign sel1 = io_pulse_one && dev_sel == DEVICE_CODE;
    assign sel2 = io_pulse_two && dev_sel == DEVICE_CODE;
    assign sel4 = io_pulse_four && dev_sel == DEVICE_CODE;
    assign keep = !bit_time_state_pulse && !initialize && !sel4;
    assign busy_chain = pri_en_n || pending != '0;
    // lowest set bit only; a disabled module selects nothing
    assign exp_win = pri_en_n ? '0 : pending & (~pending + 4'h1);

    // expected vector from flop state, lowest index wins
    always_comb begin
        exp_vec = '0;
        if (!pri_en_n) begin
            exp_vec = addr_groups[NUM_REQ*ADDR_W +: ADDR_W];
            for (int g = NUM_REQ - 1; g >= 0; g--) begin
                if (pending[g]) begin
                    exp_vec = addr_groups[g*ADDR_W +: ADDR_W];
                end
            end
        end
    end

    // ============================================================
    // properties; a frozen clock enable holds all state, so pause
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst || !ce);

    chk_vec_strobe: assert property (
        sel1 |=> acc_oe == $past(exp_vec))
        else $error("vector strobe wrong");
    chk_acc_quiet: assert property (
        !sel1 |=> acc_oe == '0)
        else $error("accumulator sunk without pulse");
    chk_clr_pulse: assert property (
        sel2 |=> clr_ac_oe ##1 !clr_ac_oe)
        else $error("clear pulse missing or long");
    chk_clr_cause: assert property (
        clr_ac_oe |-> $past(sel2))
        else $error("clear line without selected pulse");
    chk_sample_load: assert property (
        bit_time_state_pulse && !initialize && !sel4
        |=> pending == ~$past(req_n))
        else $error("sample did not load requests");
    chk_flops_hold: assert property (
        keep |=> $stable(pending))
        else $error("flops moved without cause");
    chk_end_clears: assert property (
        sel4 |=> pending == '0)
        else $error("end of service left flops set");
    chk_init_clears: assert property (
        initialize |=> pending == '0)
        else $error("initialize left flops set");
    chk_one_winner: assert property (
        !$past(srst) |-> winner == $past(exp_win))
        else $error("selection not the highest request");
    chk_chain_out: assert property (
        !$past(srst) |-> pri_out_n == $past(busy_chain))
        else $error("priority output wrong");

endmodule : piv_properties

/* testbench/testbench.sv */
`timescale 1ns/100ps
// ============================================================
// both ends joined; software view over apb
module testbench;
    import piv_pkg::*;

    localparam logic [DEV_SEL_W-1:0] CODE = 6'h15; // same on both ends
    // last module carries the non-priority group
    localparam logic [NUM_GROUPS*ADDR_W-1:0] TABLE =
        {6'h2b, 6'h38, 6'h24, 6'h12, 6'h01};

    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [NUM_REQ-1:0] device_flag = '0;
    logic [NUM_REQ-1:0] flags;
    logic [ADDR_W-1:0] grp;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [NUM_REQ-1:0] pending;
    logic [NUM_REQ-1:0] winner;
    logic [ADDR_W-1:0] acc_seen = '0;
    logic [31:0] rd;
    logic last_err;
    int n_mismatch = 0;
    int checked = 0;

    piv_if link();

    always #10 mclk = ~mclk;

    piv_controller #(.DEVICE_CODE(CODE), .ADDR_TABLE(TABLE),
        .PRI_EN_N(1'b0), .BTS_PERIOD(4)) piv_controller_inst (
        .mclk(mclk), .srst(srst), .ce(ce), .device_flag(device_flag),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .bus(link));

    priority_interrupt_vector #(.DEVICE_CODE(CODE))
        priority_interrupt_vector_inst (.mclk(mclk), .srst(srst), .ce(ce),
        .bus(link), .pending(pending), .winner(winner));

    piv_properties #(.DEVICE_CODE(CODE)) piv_properties_inst (
        .mclk(mclk), .srst(srst), .ce(ce), .dev_sel(link.dev_sel),
        .io_pulse_one(link.io_pulse_one), .io_pulse_two(link.io_pulse_two),
        .io_pulse_four(link.io_pulse_four), .initialize(link.initialize),
        .bit_time_state_pulse(link.bit_time_state_pulse),
        .req_n(link.req_n), .addr_groups(link.addr_groups),
        .pri_en_n(link.pri_en_n), .pri_out_n(link.pri_out_n),
        .acc_oe(link.acc_oe), .clr_ac_oe(link.clr_ac_oe),
        .pending(pending), .winner(winner));

    // keep the last level seen on the shared accumulator lines
    always @(posedge mclk) begin
        if (link.acc_oe != '0) begin
            acc_seen <= link.accumulator_input_bus;
        end
    end

    // ============================================================
    // reporting
    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    task automatic give_up(input string what);
        n_mismatch++;
        $display("[ERR] %0t timeout %s", $time, what);
        stop_test;
    endtask : give_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // ============================================================
    // apb master: hold the request until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) give_up("pready");
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rdchk

    // poll busy with a bounded number of reads
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            k++;
        end while (rd[STATUS_BUSY] !== 1'b0 && k < 20);
        if (k >= 20) give_up("busy");
    endtask : wait_idle

    task automatic wait_pend(input logic [NUM_REQ-1:0] exp);
        int k;
        k = 0;
        while (pending !== exp && k < 40) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 40) give_up("flops");
    endtask : wait_pend

    // ============================================================
    // main sequence
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        rdchk(OFS_IRQ_ENABLE, 32'h0, "enable reset");
        rdchk(OFS_IRQ_STATUS, 32'h0, "status reset");
        rdchk(OFS_STATUS, 32'h2, "idle status");
        apb(1'b1, 8'h20, 32'h3);
        chk({31'h0, last_err}, 32'h1, "unmapped write");
        rdchk(8'h20, 32'h0, "unmapped read");
        chk({31'h0, last_err}, 32'h1, "unmapped read err");
        // each priority as lowest set bit, then the idle group
        for (int i = 0; i <= NUM_REQ; i++) begin
            flags = (i < NUM_REQ) ? 4'hf << i : 4'h0;
            grp = TABLE[i*ADDR_W +: ADDR_W];
            device_flag <= flags;
            wait_pend(flags);
            chk({28'h0, pending}, {28'h0, flags}, "flops");
            apb(1'b1, OFS_IRQ_ENABLE, (i < NUM_REQ) ? 32'h3 : 32'h0);
            chk({28'h0, winner}, {28'h0, (i < NUM_REQ) ? 4'h1 << i : 4'h0},
                "winner");
            apb(1'b1, OFS_CMD, 32'h1);
            wait_idle;
            rdchk(OFS_VECTOR, {26'h0, grp}, "vector");
            chk({26'h0, acc_seen}, {26'h0, ~grp}, "ac");
            // chain passes on only when no flop is set
            rdchk(OFS_STATUS, {29'h0, 1'b1, i == NUM_REQ, 1'b0},
                  "status");
            rdchk(OFS_IRQ_STATUS, 32'h3, "events");
            chk({31'h0, irq}, {31'h0, i < NUM_REQ}, "irq masked");
            apb(1'b1, OFS_IRQ_CLEAR, 32'h3);
            rdchk(OFS_IRQ_STATUS, 32'h0, "events cleared");
            chk({31'h0, irq}, 32'h0, "irq cleared");
        end
        // end of service and initialize with requests standing
        device_flag <= 4'h9;
        wait_pend(4'h9);
        for (int op = 2; op <= 3; op++) begin
            apb(1'b1, OFS_CMD, op);
            wait_idle;
            rdchk(OFS_IRQ_STATUS, 32'h2, "done only");
            apb(1'b1, OFS_IRQ_CLEAR, 32'h3);
        end
        // a low clock enable holds the flops against a dropped flag
        wait_pend(4'h9);
        ce <= 1'b0;
        device_flag <= 4'h0;
        repeat (12) @(posedge mclk);
        chk({28'h0, pending}, 32'h9, "frozen flops");
        ce <= 1'b1;
        wait_pend(4'h0);
        stop_test;
    end

endmodule : testbench
